// *** brgc_regs.svh ***
// Register offsets, field positions, reset values and timing counts
`ifndef BRGC_REGS_SVH
`define BRGC_REGS_SVH
`define BRGC_CTRL_IDX     8'h01
`define BRGC_STAT_IDX     8'h02
`define BRGC_CTRL_ADDR    (32'(`BRGC_CTRL_IDX) << 2)
`define BRGC_STAT_ADDR    (32'(`BRGC_STAT_IDX) << 2)
`define BRGC_HOLDOFF_BIT  7
`define BRGC_TRIGGER_BIT  6
`define BRGC_GAP_MSB      5
`define BRGC_GAP_MAX      6'h3f
`define BRGC_GAP_RESET    6'h3f
`define BRGC_ADDR_MASK    32'h0000_00ff
`define BRGC_RESET_NS     2000
`define BRGC_CLK_NS       20
`define BRGC_RESET_CYC    ((`BRGC_RESET_NS + `BRGC_CLK_NS - 1) / `BRGC_CLK_NS)
`endif

// *** brgc_pkg.sv ***
// Types shared by the bus reset and gap count controller
package brgc_pkg;
  typedef enum logic [1:0] {
    BRGC_IDLE = 2'b00,
    BRGC_BUSY = 2'b01
  } brgc_state_t;
  typedef struct packed {
    logic       holdoff;
    logic [5:0] gap;
  } brgc_cfg_t;
endpackage

// *** brgc_top.sv ***
// Bus reset initiation, root holdoff and gap count controller with AHB-Lite slave
`timescale 1ns/10ps
`default_nettype none
`include "brgc_regs.svh"
//////////////////////////////////////////////////////////////////////////////
// Software reaches one control word and one status word over AHB-Lite with
// no wait states. Writes land in the data phase; read words are registered
// at the end of the address phase so they stand through the data phase.
// The packet and cable reset inputs come from the PHY's own packet and
// arbitration logic on hclk, so they are used without synchronisers.
// A write whose trigger bit is clear is dropped whole: holdoff and gap are
// only ever written together with a set trigger bit, which starts a bus reset only from idle.
// Same-cycle priority is trigger write, then packet, then gap fallback.
// A trigger written while the own reset runs stores the fields but does
// not restart the reset, so only a system reset ends the pulse before the full count.
// The end of the own reset counts as a bus reset for the fallback, which
// is why a trigger write clears the tracking flag.
module brgc_top
  import brgc_pkg::*;
(
  input  wire logic        hclk,          // System clock
  input  wire logic        hresetn,       // Async reset, active low
  input  wire logic        hsel,          // Slave select
  input  wire logic [31:0] haddr,         // Byte address
  input  wire logic [1:0]  htrans,        // Transfer type
  input  wire logic        hwrite,        // Write strobe
  input  wire logic [2:0]  hsize,         // Transfer size
  input  wire logic [31:0] hwdata,        // Write data
  input  wire logic        hready,        // Bus ready in
  output logic      [31:0] hrdata,        // Read data
  output logic             hreadyout,     // Always ready
  output logic             hresp,         // Always OKAY
  input  wire logic        cfg_pkt_valid, // Config packet sent or received
  input  wire logic        cfg_pkt_rhb,   // Holdoff from packet
  input  wire logic [5:0]  cfg_pkt_gap,   // Gap count from packet
  input  wire logic        bus_reset_in,  // Bus reset seen on cable
  output logic             bus_reset_out, // Drive bus reset, level
  output logic             root_holdoff_flag, // Current holdoff
  output logic      [5:0]  gap_count      // Current gap count
);
  //////////////////////////////////////////////////////////////////////////////
  // Bus address phase capture
  logic        wr_pend_q, wr_pend_d;
  logic        rd_ctrl_q, rd_ctrl_d;
  logic [31:0] addr_q, addr_d;
  logic        ap_valid;
  assign ap_valid = hsel && hready && htrans[1];
  // Decode the address phase into a pending write or read
  always_comb begin
    wr_pend_d = ap_valid && hwrite;
    rd_ctrl_d = ap_valid && !hwrite;
    addr_d    = ap_valid ? (haddr & `BRGC_ADDR_MASK) : addr_q;
  end
  // Address phase registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
      rd_ctrl_q <= 1'b0;
      addr_q    <= 32'h0000_0000;
    end else begin
      wr_pend_q <= wr_pend_d;
      rd_ctrl_q <= rd_ctrl_d;
      addr_q    <= addr_d;
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  // Control state: holdoff, gap, reset tracking and reset generator
  brgc_cfg_t   cfg_q, cfg_d;
  logic        seen_q, seen_d;
  brgc_state_t st_q, st_d;
  logic [7:0]  cnt_q, cnt_d;
  logic        ctrl_wr, trig_wr, bus_rst_ev, gap_upd;
  // Write strobe, bus reset event and gap update decode
  assign ctrl_wr    = wr_pend_q && (addr_q == `BRGC_CTRL_ADDR);
  assign trig_wr    = ctrl_wr && hwdata[`BRGC_TRIGGER_BIT];
  assign bus_rst_ev = bus_reset_in || (st_q == BRGC_BUSY && cnt_q == 8'h01);
  assign gap_upd    = trig_wr || cfg_pkt_valid;
  always_comb begin
    cfg_d  = cfg_q;
    seen_d = seen_q;
    st_d   = st_q;
    cnt_d  = cnt_q;
    // Second reset with no update in between falls back to max gap
    if (bus_rst_ev) begin
      if (seen_q && !gap_upd) begin
        cfg_d.gap = `BRGC_GAP_MAX;
      end
      seen_d = 1'b1;
    end
    // Packet load from either direction
    if (cfg_pkt_valid) begin
      cfg_d.holdoff = cfg_pkt_rhb;
      cfg_d.gap     = cfg_pkt_gap;
      seen_d        = 1'b0;
    end
    // Trigger write stores fields and clears tracking; from idle it also arms own reset
    if (trig_wr) begin
      cfg_d.holdoff = hwdata[`BRGC_HOLDOFF_BIT];
      cfg_d.gap     = hwdata[`BRGC_GAP_MSB:0];
      seen_d        = 1'b0;
    end
    case (st_q)
      BRGC_IDLE: begin
        // Trigger from idle arms the own reset; while busy it only stores
        if (trig_wr) begin
          st_d  = BRGC_BUSY;
          cnt_d = 8'(`BRGC_RESET_CYC);
        end
      end
      BRGC_BUSY: begin
        // Count down; the last busy cycle counts as a bus reset event
        cnt_d = cnt_q - 8'h01;
        if (cnt_q == 8'h01) begin
          st_d = BRGC_IDLE;
        end
      end
      default: begin
        st_d = BRGC_IDLE;
      end
    endcase
  end
  // Control state registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cfg_q  <= '{holdoff: 1'b0, gap: `BRGC_GAP_RESET};
      seen_q <= 1'b0;
      st_q   <= BRGC_IDLE;
      cnt_q  <= 8'h00;
    end else begin
      cfg_q  <= cfg_d;
      seen_q <= seen_d;
      st_q   <= st_d;
      cnt_q  <= cnt_d;
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  // Registered outputs and read data
  logic [31:0] rdata_d;
  // Read word from next state values so it matches the data phase
  always_comb begin
    rdata_d = 32'h0000_0000;
    if (rd_ctrl_d && ((haddr & `BRGC_ADDR_MASK) == `BRGC_CTRL_ADDR)) begin
      rdata_d = {24'h000000, cfg_d.holdoff, (st_d == BRGC_BUSY), cfg_d.gap};
    end else if (rd_ctrl_d && ((haddr & `BRGC_ADDR_MASK) == `BRGC_STAT_ADDR)) begin
      rdata_d = {30'h0000_0000, seen_d, (st_d == BRGC_BUSY)};
    end
  end
  // Output registers; the bus response is fixed at ready and OKAY
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata            <= 32'h0000_0000;
      hreadyout         <= 1'b1;
      hresp             <= 1'b0;
      bus_reset_out     <= 1'b0;
      root_holdoff_flag <= 1'b0;
      gap_count         <= `BRGC_GAP_RESET;
    end else begin
      hrdata            <= rdata_d;
      hreadyout         <= 1'b1;
      hresp             <= 1'b0;
      bus_reset_out     <= (st_d == BRGC_BUSY);
      root_holdoff_flag <= cfg_d.holdoff;
      gap_count         <= cfg_d.gap;
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  // Helper: cycles the own bus reset has been driven so far
  logic [7:0]  rst_len_q, rst_len_d;
  always_comb begin
    rst_len_d = bus_reset_out ? (rst_len_q + 8'h01) : 8'h00;
  end
  // Helper register, cleared with the rest of the block
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rst_len_q <= 8'h00;
    end else begin
      rst_len_q <= rst_len_d;
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  // Checks
  // Trigger write from idle raises the own reset next cycle
  a_trig_starts: assert property (@(posedge hclk) disable iff (!hresetn)
    (trig_wr && st_q == BRGC_IDLE) |=> bus_reset_out)
    else $error("trigger write did not start bus reset");
  // Own reset lasts the full count and never longer
  a_rst_length: assert property (@(posedge hclk) disable iff (!hresetn)
    $fell(bus_reset_out) |-> rst_len_q == 8'(`BRGC_RESET_CYC))
    else $error("own bus reset ended at the wrong length");
  a_rst_bound: assert property (@(posedge hclk) disable iff (!hresetn)
    bus_reset_out |-> rst_len_q < 8'(`BRGC_RESET_CYC))
    else $error("own bus reset ran too long");
  // Trigger write stores holdoff and gap, over any packet in that cycle
  a_trig_stores: assert property (@(posedge hclk) disable iff (!hresetn)
    trig_wr |=> (gap_count == $past(hwdata[`BRGC_GAP_MSB:0]) &&
                 root_holdoff_flag == $past(hwdata[`BRGC_HOLDOFF_BIT])))
    else $error("trigger write did not store fields");
  // Packet loads both fields when no trigger write competes
  a_pkt_loads: assert property (@(posedge hclk) disable iff (!hresetn)
    (cfg_pkt_valid && !trig_wr) |=> gap_count == $past(cfg_pkt_gap))
    else $error("config packet did not load gap");
  a_pkt_holdoff: assert property (@(posedge hclk) disable iff (!hresetn)
    (cfg_pkt_valid && !trig_wr) |=> root_holdoff_flag == $past(cfg_pkt_rhb))
    else $error("config packet did not load holdoff");
  // Second reset without update falls back to the maximum gap
  a_gap_fallback: assert property (@(posedge hclk) disable iff (!hresetn)
    (bus_rst_ev && seen_q && !gap_upd) |=> gap_count == `BRGC_GAP_MAX)
    else $error("gap did not fall back to max");
  // Gap moves only on an update or a bus reset
  a_gap_steady: assert property (@(posedge hclk) disable iff (!hresetn)
    (!bus_rst_ev && !gap_upd) |=> $stable(gap_count))
    else $error("gap changed without cause");
  // Own trigger clears tracking so its reset keeps the new gap
  a_own_keep: assert property (@(posedge hclk) disable iff (!hresetn)
    trig_wr |=> !seen_q)
    else $error("own reset would revert written gap");
  // Tracking flag follows resets and updates
  a_seen_set: assert property (@(posedge hclk) disable iff (!hresetn)
    (bus_rst_ev && !gap_upd) |=> seen_q)
    else $error("reset tracking flag not set");
  a_seen_clear: assert property (@(posedge hclk) disable iff (!hresetn)
    gap_upd |=> !seen_q)
    else $error("reset tracking flag not cleared");
endmodule
`default_nettype wire

// *** brgc_node_model.sv ***
// Model of the other nodes on the cable bus
`timescale 1ns/10ps
`default_nettype none
module brgc_node_model (
  input  wire logic       hclk,          // Clock
  output logic            cfg_pkt_valid, // Config packet pulse
  output logic            cfg_pkt_rhb,   // Packet holdoff
  output logic      [5:0] cfg_pkt_gap,   // Packet gap count
  output logic            bus_reset_in   // Cable reset pulse
);
  initial begin
    cfg_pkt_valid = 1'b0;
    cfg_pkt_rhb = 1'b1;
    cfg_pkt_gap = 6'h2a;
    bus_reset_in = 1'b0;
  end
  // One packet cycle, then fields turn to garbage
  task automatic cfg(input logic r, input logic [5:0] g);
    @(posedge hclk);
    {cfg_pkt_valid, cfg_pkt_rhb, cfg_pkt_gap} <= {1'b1, r, g};
    @(posedge hclk);
    {cfg_pkt_valid, cfg_pkt_rhb, cfg_pkt_gap} <= {1'b0, ~r, ~g};
  endtask
  // Reset seen when another node connects
  task automatic cable_reset;
    @(posedge hclk);
    bus_reset_in <= 1'b1;
    @(posedge hclk);
    bus_reset_in <= 1'b0;
  endtask
endmodule
`default_nettype wire

// *** tb.sv ***
// Testbench for the bus reset and gap count controller
`timescale 1ns/10ps
`default_nettype none
`include "brgc_regs.svh"
module tb;
  logic        hclk = 0;
  logic        hresetn = 0;
  logic        hsel = 0;
  logic [31:0] haddr = '0;
  logic [1:0]  htrans = '0;
  logic        hwrite = 0;
  logic [2:0]  hsize = 3'h2;
  logic [31:0] hwdata = '0;
  logic [31:0] hrdata, r;
  logic        hreadyout, hresp, cv, crhb, bri, bro, rhf;
  logic [5:0]  cgap, gap;
  int          error_cnt = 0, num_checks = 0, cyc = 0, n;
  logic [6:0]  pk [3] = '{7'h3f, 7'h45, 7'h0c};
  logic [7:0]  rd [3] = '{8'h3f, 8'h85, 8'h0c};
  wire logic   hready = hreadyout;
  always #10 hclk = ~hclk;
  brgc_top brgc_top_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .cfg_pkt_valid(cv),
    .cfg_pkt_rhb(crhb), .cfg_pkt_gap(cgap), .bus_reset_in(bri), .bus_reset_out(bro),
    .root_holdoff_flag(rhf), .gap_count(gap));
  brgc_node_model brgc_node_model_inst (.hclk(hclk), .cfg_pkt_valid(cv),
    .cfg_pkt_rhb(crhb), .cfg_pkt_gap(cgap), .bus_reset_in(bri));
  ////////////////////////////////////////////////////////////////////////////////
  // One AHB-Lite single word transfer
  task automatic xfer(input logic w, input logic [31:0] a, d);
    hsel <= 1'b1;
    {haddr, hwrite, htrans} <= {a, w, 2'b10};
    do @(posedge hclk); while (hready !== 1'b1);
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge hclk); while (hready !== 1'b1);
    r = hrdata;
  endtask
  task automatic chk(input logic [31:0] got, exp);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic summarize;
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // Cuts a hang short
  always @(posedge hclk) begin
    cyc++;
    if (cyc == 5000) begin error_cnt++; summarize(); end
  end
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (4) @(posedge hclk);
    chk({hreadyout, hresp, bro, rhf, gap}, {4'h8, 6'h3f});
    hresetn <= 1'b1;
    @(posedge hclk);
    // Rows: packet, read back, matching trigger rewrite, own reset to its end
    for (int i = 0; i < 3; i++) begin
      brgc_node_model_inst.cfg(pk[i][6], pk[i][5:0]);
      repeat (2) @(posedge hclk);
      chk({rhf, gap}, pk[i]);
      xfer(1'b0, `BRGC_CTRL_ADDR, 32'h0);
      chk(r, rd[i]);
      xfer(1'b1, `BRGC_CTRL_ADDR, {24'h0, rd[i] | 8'h40});
      @(posedge hclk);
      chk({rhf, gap}, pk[i]);
      for (n = 0; bro; n++) @(posedge hclk);
      chk(n, `BRGC_RESET_CYC);
      chk({rhf, gap}, pk[i]);
    end
    // Own reset was the first; a cable reset then falls back
    xfer(1'b0, `BRGC_STAT_ADDR, 32'h0);
    chk(r, 32'h2);
    brgc_node_model_inst.cable_reset();
    repeat (2) @(posedge hclk);
    chk(gap, 6'h3f);
    // Received packet, then two cable resets
    brgc_node_model_inst.cfg(1'b1, 6'h0c);
    repeat (2) @(posedge hclk);
    chk({rhf, gap}, 7'h4c);
    xfer(1'b0, `BRGC_STAT_ADDR, 32'h0);
    chk(r, 32'h0);
    brgc_node_model_inst.cable_reset();
    repeat (2) @(posedge hclk);
    chk(gap, 6'h0c);
    brgc_node_model_inst.cable_reset();
    repeat (2) @(posedge hclk);
    chk(gap, 6'h3f);
    // Plain trigger reset: gap 63, holdoff written as 1; a system reset cuts it
    brgc_node_model_inst.cfg(1'b1, 6'h0c);
    repeat (2) @(posedge hclk);
    xfer(1'b1, `BRGC_CTRL_ADDR, 32'hff);
    @(posedge hclk);
    chk({rhf, gap, bro}, 8'hff);
    hresetn <= 1'b0;
    @(posedge hclk);
    chk({hreadyout, hresp, bro, rhf, gap}, {4'h8, 6'h3f});
    hresetn <= 1'b1;
    @(posedge hclk);
    // Awkward case: a write with the trigger clear is dropped whole
    xfer(1'b1, `BRGC_CTRL_ADDR, 32'h0a);
    @(posedge hclk);
    chk({rhf, gap, bro}, 8'h7e);
    xfer(1'b0, 32'h10, 32'h0);
    chk(r, 32'h0);
    summarize();
  end
endmodule
`default_nettype wire
